// *** inc/keg_pair_pkg.sv ***
/*
 * constants for the keg tag pairing controller: tag page numbers,
 * default hold, timeout and blink timings, reset values.
 * assumes a 100 MHz system clock.
 */
package keg_pair_pkg;
	localparam int clk_mhz = 100;
	localparam logic [7:0] page_uid_lo = 8'h00;
	localparam logic [7:0] page_uid_hi = 8'h01;
	localparam logic [7:0] page_spec_lo = 8'h02;
	localparam logic [7:0] page_spec_hi = 8'h03;
	localparam logic [7:0] page_user_lo = 8'h04;
	localparam logic [7:0] page_user_hi = 8'h05;
	localparam int user_bits = 64;
	localparam int word_bits = 32;
	localparam int blink_count = 2;
	localparam int hold_ms = 2000;
	localparam int timeout_ms = 30000;
	localparam int blink_ms = 250;
	localparam int hold_cycles = hold_ms * 1000 * clk_mhz;
	// unsigned: the default count does not fit a signed 32-bit value
	localparam int unsigned timeout_cycles =
		unsigned'(timeout_ms) * 1000 * clk_mhz;
	localparam int blink_cycles = blink_ms * 1000 * clk_mhz;
	localparam logic [63:0] store_rst = 64'h0;
	typedef enum logic [2:0] {
		st_idle, st_pair, st_rd_lo, st_rd_hi, st_blink, st_quiet
	} state_t;
endpackage

// *** verilog/keg_tag_pairing_control.sv ***
/*
 * pairing controller: button hold detection, led indication and a
 * two-page user value fetch from a tag via a reader ic.
 * assumes button, battery flag and reader answers synchronous to clk;
 * the reader answers each page request with rd_done and rd_ok.
 */
`timescale 1ns/100ps
// Function
// - the user value is fetched as page four then page five, 32 bits each.
// - pages zero and one hold the tag identifier and never enter the store.
// - pages two and three are never requested for pairing.
// - there are primary and secondary stores; a good primary read clears sec_valid_r.
// - a primary read starts only after a hold long enough to light the led.
// - a good read flashes the led twice, or not at all with low battery, and then leaves it off.
// - a second full hold in the pairing state, reached again after a failed read, sends the next read to the secondary store.
// - in the pairing state the reader is enabled and the led is steadily on.
// - on timeout the led goes off, stores are kept and the prior state returns.
// - with low battery the led stays off during pairing.
module keg_tag_pairing_control #(
	parameter int hold_cyc = keg_pair_pkg::hold_cycles,
	parameter int unsigned timeout_cyc = keg_pair_pkg::timeout_cycles,
	parameter int blink_cyc = keg_pair_pkg::blink_cycles
) (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, high
	input wire logic button, // pairing button, high when pressed
	input wire logic batt_low, // battery below usable level
	input wire logic rd_done, // reader finished page request
	input wire logic rd_ok, // reader page data valid
	input wire logic [31:0] rd_data, // reader page word
	output logic rd_en_r, // reader powered
	output logic rd_req_r, // page request pulse
	output logic [7:0] rd_page_r, // requested page
	output logic led_r, // red led
	output logic [63:0] prim_r, // primary tag value
	output logic [63:0] sec_r, // secondary tag value
	output logic sec_valid_r, // secondary stacked entry held
	output logic paired_r // a tag was paired since reset
);
	keg_pair_pkg::state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt, tmo_r, tmo_nxt;
	logic [31:0] lo_r, lo_nxt;
	logic [2:0] ph_r, ph_nxt;
	logic to_sec_r, to_sec_nxt, armed_r, armed_nxt;
	logic rd_en_nxt, rd_req_nxt, led_nxt, sec_valid_nxt, paired_nxt;
	logic [7:0] rd_page_nxt;
	logic [63:0] prim_nxt, sec_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		tmo_nxt = tmo_r;
		lo_nxt = lo_r;
		ph_nxt = ph_r;
		to_sec_nxt = to_sec_r;
		armed_nxt = armed_r;
		rd_en_nxt = rd_en_r;
		rd_req_nxt = 1'b0;
		rd_page_nxt = rd_page_r;
		led_nxt = led_r;
		prim_nxt = prim_r;
		sec_nxt = sec_r;
		sec_valid_nxt = sec_valid_r;
		paired_nxt = paired_r;
		case (st_r)
			keg_pair_pkg::st_idle: begin
				led_nxt = 1'b0;
				rd_en_nxt = 1'b0;
				if (!button) begin
					cnt_nxt = 32'h0;
				end else if (cnt_r >= 32'(hold_cyc - 1)) begin
					st_nxt = keg_pair_pkg::st_pair;
					to_sec_nxt = 1'b0;
					armed_nxt = 1'b0;
					tmo_nxt = 32'h0;
					cnt_nxt = 32'h0;
					rd_en_nxt = 1'b1;
					led_nxt = !batt_low;
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			keg_pair_pkg::st_pair: begin
				rd_en_nxt = 1'b1;
				led_nxt = !batt_low;
				tmo_nxt = tmo_r + 32'h1;
				if (!button) begin
					cnt_nxt = 32'h0;
					armed_nxt = 1'b1;
				end else if (armed_r && !to_sec_r) begin
					if (cnt_r >= 32'(hold_cyc - 1)) begin
						to_sec_nxt = 1'b1;
						tmo_nxt = 32'h0;
					end else begin
						cnt_nxt = cnt_r + 32'h1;
					end
				end
				if (!button) begin
					st_nxt = keg_pair_pkg::st_rd_lo;
					rd_req_nxt = 1'b1;
					rd_page_nxt = keg_pair_pkg::page_user_lo;
				end
			end
			keg_pair_pkg::st_rd_lo: begin
				tmo_nxt = tmo_r + 32'h1;
				led_nxt = !batt_low;
				if (rd_done && rd_ok) begin
					lo_nxt = rd_data;
					st_nxt = keg_pair_pkg::st_rd_hi;
					rd_req_nxt = 1'b1;
					rd_page_nxt = keg_pair_pkg::page_user_hi;
				end else if (rd_done) begin
					st_nxt = keg_pair_pkg::st_pair;
				end
			end
			keg_pair_pkg::st_rd_hi: begin
				tmo_nxt = tmo_r + 32'h1;
				led_nxt = !batt_low;
				if (rd_done && rd_ok) begin
					if (to_sec_r) begin
						sec_nxt = {rd_data, lo_r};
						sec_valid_nxt = 1'b1;
					end else begin
						prim_nxt = {rd_data, lo_r};
						sec_valid_nxt = 1'b0;
					end
					paired_nxt = 1'b1;
					rd_en_nxt = 1'b0;
					led_nxt = 1'b0;
					ph_nxt = 3'h0;
					cnt_nxt = 32'h0;
					st_nxt = keg_pair_pkg::st_blink;
				end else if (rd_done) begin
					st_nxt = keg_pair_pkg::st_pair;
				end
			end
			keg_pair_pkg::st_blink: begin
				if (cnt_r >= 32'(blink_cyc - 1)) begin
					cnt_nxt = 32'h0;
					ph_nxt = ph_r + 3'h1;
					if (ph_r == 3'(2 * keg_pair_pkg::blink_count - 1)) begin
						st_nxt = keg_pair_pkg::st_quiet;
						led_nxt = 1'b0;
					end else begin
						led_nxt = !ph_r[0] && !batt_low;
					end
				end else begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			default: begin
				led_nxt = 1'b0;
				cnt_nxt = 32'h0;
				if (!button) begin
					st_nxt = keg_pair_pkg::st_idle;
				end
			end
		endcase
		// timeout also cuts a read in flight; a completed value still wins
		if (tmo_r >= 32'(timeout_cyc - 1)
			&& (st_r == keg_pair_pkg::st_pair
			|| st_r == keg_pair_pkg::st_rd_lo
			|| (st_r == keg_pair_pkg::st_rd_hi
			&& !(rd_done && rd_ok)))) begin
			st_nxt = keg_pair_pkg::st_idle;
			led_nxt = 1'b0;
			rd_en_nxt = 1'b0;
			rd_req_nxt = 1'b0;
			cnt_nxt = 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= keg_pair_pkg::st_idle;
			cnt_r <= 32'h0;
			tmo_r <= 32'h0;
			lo_r <= 32'h0;
			ph_r <= 3'h0;
			to_sec_r <= 1'b0;
			armed_r <= 1'b0;
			rd_en_r <= 1'b0;
			rd_req_r <= 1'b0;
			rd_page_r <= 8'h00;
			led_r <= 1'b0;
			prim_r <= keg_pair_pkg::store_rst;
			sec_r <= keg_pair_pkg::store_rst;
			sec_valid_r <= 1'b0;
			paired_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			tmo_r <= tmo_nxt;
			lo_r <= lo_nxt;
			ph_r <= ph_nxt;
			to_sec_r <= to_sec_nxt;
			armed_r <= armed_nxt;
			rd_en_r <= rd_en_nxt;
			rd_req_r <= rd_req_nxt;
			rd_page_r <= rd_page_nxt;
			led_r <= led_nxt;
			prim_r <= prim_nxt;
			sec_r <= sec_nxt;
			sec_valid_r <= sec_valid_nxt;
			paired_r <= paired_nxt;
		end
	end

	property p_page_order;
		@(posedge clk) disable iff (srst)
		rd_req_r |-> (rd_page_r == keg_pair_pkg::page_user_lo
		|| rd_page_r == keg_pair_pkg::page_user_hi);
	endproperty
	a_page_order: assert property (p_page_order)
		else $error("page outside user area requested");

	property p_hi_after_lo;
		@(posedge clk) disable iff (srst)
		(rd_req_r && rd_page_r == keg_pair_pkg::page_user_hi) |->
		$past(st_r) == keg_pair_pkg::st_rd_lo;
	endproperty
	a_hi_after_lo: assert property (p_hi_after_lo)
		else $error("page five not preceded by page four");

	property p_pair_led;
		@(posedge clk) disable iff (srst)
		(st_r == keg_pair_pkg::st_pair && $past(st_r) ==
		keg_pair_pkg::st_pair) |-> rd_en_r && (led_r == !$past(batt_low));
	endproperty
	a_pair_led: assert property (p_pair_led)
		else $error("pairing state without reader or steady led");

	property p_low_batt;
		@(posedge clk) disable iff (srst)
		($past(batt_low) && st_r != keg_pair_pkg::st_blink) |-> !led_r;
	endproperty
	a_low_batt: assert property (p_low_batt)
		else $error("led lit with low battery");

	property p_blink_end;
		@(posedge clk) disable iff (srst)
		(st_r == keg_pair_pkg::st_quiet) |-> !led_r;
	endproperty
	a_blink_end: assert property (p_blink_end)
		else $error("led not off after blinks");

	property p_sec_keep;
		@(posedge clk) disable iff (srst)
		(st_r == keg_pair_pkg::st_rd_hi && rd_done && rd_ok && to_sec_r)
		|=> prim_r == $past(prim_r) && sec_valid_r;
	endproperty
	a_sec_keep: assert property (p_sec_keep)
		else $error("secondary read disturbed primary store");

	property p_timeout;
		@(posedge clk) disable iff (srst)
		(tmo_r >= 32'(timeout_cyc - 1)
		&& (st_r == keg_pair_pkg::st_pair
		|| st_r == keg_pair_pkg::st_rd_lo
		|| (st_r == keg_pair_pkg::st_rd_hi && !(rd_done && rd_ok))))
		|=> st_r == keg_pair_pkg::st_idle && !led_r
		&& prim_r == $past(prim_r) && sec_r == $past(sec_r);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout did not restore idle");

	property p_enter_pair;
		@(posedge clk) disable iff (srst)
		(st_r == keg_pair_pkg::st_pair && $past(st_r) ==
		keg_pair_pkg::st_idle) |-> $past(button) &&
		$past(cnt_r) >= 32'(hold_cyc - 1);
	endproperty
	a_enter_pair: assert property (p_enter_pair)
		else $error("pairing entered without full hold");
endmodule

// *** tb/tag_reader_model.sv ***
/*
 * behavioural reader ic: answers each page request after lat cycles.
 * assumes one clock shared with the controller.
 */
`timescale 1ns/100ps
module tag_reader_model #(
	parameter int lat = 5
) (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, high
	input wire logic rd_req_r, // page request pulse
	input wire logic [7:0] rd_page_r, // requested page
	input wire logic fail, // answer with a failed read
	input wire logic [31:0] tag, // tag contents seed
	output logic rd_done, // request finished
	output logic rd_ok, // data valid
	output logic [31:0] rd_data, // page word
	output logic bad_page // page outside the user area asked for
);
	int cnt;
	logic [7:0] pg;
	always @(posedge clk) begin
		if (srst) begin
			cnt <= 0;
			pg <= 8'h00;
			bad_page <= 1'b0;
			rd_done <= 1'b0;
			rd_ok <= 1'b0;
			rd_data <= 32'h0;
		end else if (rd_req_r) begin
			cnt <= lat;
			pg <= rd_page_r;
			rd_done <= 1'b0;
			rd_ok <= 1'b0;
			rd_data <= ~rd_data;
			if (rd_page_r < 8'h04 || rd_page_r > 8'h05)
				bad_page <= 1'b1;
		end else if (cnt == 1) begin
			cnt <= 0;
			rd_done <= 1'b1;
			rd_ok <= !fail;
			rd_data <= tag ^ {24'h0, pg};
		end else begin
			// word is stale outside the answer cycle
			if (cnt > 0)
				cnt <= cnt - 1;
			rd_done <= 1'b0;
			rd_ok <= 1'b0;
			rd_data <= ~rd_data;
		end
	end
endmodule

// *** tb/keg_tag_pairing_control_tb_top.sv ***
/*
 * self-checking bench for the pairing controller.
 * assumes short hold, timeout and blink parameters.
 */
`timescale 1ns/100ps
module keg_tag_pairing_control_tb_top;
	localparam int hc = 4;
	localparam int tc = 200;
	localparam int bc = 3;
	logic clk = 0, srst = 1, button = 0, batt_low = 0, fail = 0;
	logic [31:0] tag = 32'h0, rd_data;
	logic rd_done, rd_ok, bad_page, rd_en_r, rd_req_r, led_r;
	logic sec_valid_r, paired_r;
	logic [7:0] rd_page_r;
	logic [63:0] prim_r, sec_r, p_old;
	int errors = 0, n_checks = 0, f, i;
	always #5 clk = ~clk;
	keg_tag_pairing_control #(.hold_cyc(hc), .timeout_cyc(tc),
		.blink_cyc(bc)) uut (.clk, .srst, .button, .batt_low, .rd_done,
		.rd_ok, .rd_data, .rd_en_r, .rd_req_r, .rd_page_r, .led_r,
		.prim_r, .sec_r, .sec_valid_r, .paired_r);
	tag_reader_model rdr (.clk, .srst, .rd_req_r, .rd_page_r, .fail,
		.tag, .rd_done, .rd_ok, .rd_data, .bad_page);
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task enter;
		@(posedge clk);
		button <= 1'b1;
		tick(hc + 2);
		@(negedge clk);
		chk(led_r, !batt_low);
		chk(rd_en_r, 1);
		@(posedge clk);
		button <= 1'b0;
	endtask
	task finish_read(output int fl);
		logic lp;
		int k;
		fl = 0;
		k = 0;
		while (rd_en_r === 1'b1 && k < 600) begin
			@(negedge clk);
			k++;
		end
		if (k == 600) begin
			errors++;
			report_and_stop;
		end
		lp = led_r;
		for (k = 0; k < 8 * bc; k++) begin
			@(negedge clk);
			if (led_r === 1'b1 && lp === 1'b0)
				fl++;
			lp = led_r;
		end
	endtask
	function automatic logic [63:0] val(input logic [31:0] t);
		return {t ^ 32'h5, t ^ 32'h4};
	endfunction
	task t_pri;
		tag <= 32'ha5a50000;
		enter();
		finish_read(f);
		chk(f, 2);
		chk(prim_r, val(tag));
		chk(bad_page, 0);
		chk(rd_page_r, 8'h05);
		chk(paired_r, 1);
		$display("t_pri done");
	endtask
	task t_short;
		@(posedge clk);
		button <= 1'b1;
		tick(hc - 2);
		button <= 1'b0;
		tick(3);
		@(negedge clk);
		chk({led_r, rd_en_r}, 0);
		$display("t_short done");
	endtask
	task t_sec;
		p_old = prim_r;
		tag <= 32'h3c3c0000;
		fail <= 1'b1;
		enter();
		tick(2);
		button <= 1'b1;
		tick(hc + 14);
		fail <= 1'b0;
		button <= 1'b0;
		finish_read(f);
		chk(f, 2);
		chk(sec_r, val(tag));
		chk(sec_valid_r, 1);
		chk(prim_r, p_old);
		$display("t_sec done");
	endtask
	task t_tmo;
		p_old = sec_r;
		fail <= 1'b1;
		enter();
		for (i = 0; i < tc + 50 && rd_en_r === 1'b1; i++)
			@(negedge clk);
		chk(i >= tc - 8 && i <= tc, 1);
		chk({led_r, rd_en_r}, 0);
		chk(sec_r, p_old);
		chk(prim_r, val(32'ha5a50000));
		@(posedge clk);
		fail <= 1'b0;
		$display("t_tmo done");
	endtask
	task t_low;
		batt_low <= 1'b1;
		tag <= 32'h0f0f0000;
		enter();
		finish_read(f);
		chk(f, 0);
		chk(prim_r, val(tag));
		chk(sec_valid_r, 0);
		@(posedge clk);
		batt_low <= 1'b0;
		$display("t_low done");
	endtask
	initial begin
		tick(16);
		srst <= 1'b0;
		@(negedge clk);
		chk({led_r, rd_en_r, paired_r, sec_valid_r}, 0);
		chk(prim_r, 0);
		t_pri();
		t_short();
		t_sec();
		t_tmo();
		t_low();
		report_and_stop();
	end
endmodule
